// >>> acfg_pkg.sv
// package: constants, types and helpers for the converter configuration block
package acfg_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] CFG_IDX = 8'h97;
  localparam logic [7:0] ACC_IDX = 8'hba;
  localparam logic [7:0] RLO_IDX = 8'hbd;
  localparam logic [7:0] RHI_IDX = 8'hbe;
  localparam logic [7:0] CTL_IDX = 8'hc0;
  localparam logic [7:0] STS_IDX = 8'hc1;
  localparam logic [7:0] MSK_IDX = 8'hc2;

  // field positions
  localparam int DIV_HI     = 7;
  localparam int DIV_LO     = 3;
  localparam int EIGHT_BIT  = 2;
  localparam int TRACK_BIT  = 1;
  localparam int GAIN_BIT   = 0;
  localparam int TWELVE_BIT = 7;
  localparam int ACCUM_BIT  = 6;
  localparam int FMT_HI     = 5;
  localparam int FMT_LO     = 3;
  localparam int RPT_HI     = 2;
  localparam int RPT_LO     = 0;
  localparam int ENA_BIT    = 0;
  localparam int BURST_BIT  = 1;
  localparam int START_BIT  = 2;
  localparam int DONE_BIT   = 0;

  // reset values
  localparam logic [7:0] CFG_RST = 8'hf8;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] CTL_RST = 8'h00;

  // timing in conversion clocks
  localparam logic [1:0] TRACK_CYCLES = 2'h3;

  // resolution codes driven to the converter
  localparam logic [1:0] RES10 = 2'h0;
  localparam logic [1:0] RES8  = 2'h1;
  localparam logic [1:0] RES12 = 2'h2;

  typedef enum logic [3:0] {
    SQ_IDLE  = 4'b0001,
    SQ_TRACK = 4'b0010,
    SQ_CONV  = 4'b0100,
    SQ_WAIT  = 4'b1000
  } acfg_state_t;

  // controls toward the analog converter
  typedef struct packed {
    logic       sar_clk;
    logic       conv_start;
    logic       gain;
    logic [1:0] res_mode;
  } acfg_ctl_t;

  // result from the analog converter
  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } acfg_res_t;

  // repeat code to last burst index; reserved codes act as 64
  function automatic logic [6:0] acfg_rpt_last(input logic [2:0] code);
    case (code)
      3'h0:    acfg_rpt_last = 7'h00;
      3'h1:    acfg_rpt_last = 7'h03;
      3'h2:    acfg_rpt_last = 7'h07;
      3'h3:    acfg_rpt_last = 7'h0f;
      3'h4:    acfg_rpt_last = 7'h1f;
      default: acfg_rpt_last = 7'h3f;
    endcase
  endfunction

endpackage

// >>> acfg_top.sv
// converter clock, mode and accumulator configuration block with apb slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
module acfg_top
  import acfg_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // low-power oscillator pin
  input  wire logic        lposc_clk,
  // analog converter
  input  wire acfg_res_t   conv_res,
  output acfg_ctl_t        conv_ctl,
  // interrupt
  output logic             irq
);

  // ==========================================================
  // input synchronisers
  acfg_res_t res_s1, res_s2;
  logic      done_s3, lp_s1, lp_s2, lp_s3;

  // two flops on the converter result and oscillator inputs, third flop for edges; apb inputs are not synchronised
  always_ff @(posedge clk) begin
    if (reset) begin
      res_s1  <= '0;
      res_s2  <= '0;
      done_s3 <= 1'b0;
      lp_s1   <= 1'b0;
      lp_s2   <= 1'b0;
      lp_s3   <= 1'b0;
    end else begin
      res_s1  <= conv_res;
      res_s2  <= res_s1;
      done_s3 <= res_s2.done;
      lp_s1   <= lposc_clk;
      lp_s2   <= lp_s1;
      lp_s3   <= lp_s2;
    end
  end

  // ==========================================================
  // registers and apb decode
  logic [7:0]  cfg_reg, acc_cfg_reg, sts_reg, sts_next, msk_reg;
  logic [1:0]  ctl_reg;
  logic [15:0] accum_reg, fmtd;
  logic [7:0]  idx;
  logic        setup, wr, start_go, hit;
  logic [31:0] rd_next;

  assign idx      = paddr[9:2];
  assign setup    = psel & ~penable;
  assign wr       = psel & penable & pready & pwrite;
  assign start_go = wr && idx == CTL_IDX && pwdata[START_BIT];

  wire       burst   = ctl_reg[BURST_BIT];
  wire       enable  = ctl_reg[ENA_BIT];
  wire [4:0] div     = cfg_reg[DIV_HI:DIV_LO];
  wire       delayed = cfg_reg[TRACK_BIT];
  wire       twelve  = acc_cfg_reg[TWELVE_BIT];
  wire       accsel  = acc_cfg_reg[ACCUM_BIT];
  wire [2:0] fmt     = acc_cfg_reg[FMT_HI:FMT_LO];
  wire [2:0] rpt     = acc_cfg_reg[RPT_HI:RPT_LO];

  // result format
  // left justify shifts by unused result bits; reserved codes act as left justify
  always_comb begin
    fmtd = accum_reg >> fmt[1:0];
    if (fmt[2]) begin
      if (twelve)
        fmtd = accum_reg << 4;
      else if (cfg_reg[EIGHT_BIT])
        fmtd = accum_reg << 8;
      else
        fmtd = accum_reg << 6;
    end
  end

  // read mux, decided in the setup cycle
  always_comb begin
    hit     = 1'b1;
    rd_next = '0;
    case (idx)
      CFG_IDX: rd_next[7:0] = cfg_reg;
      ACC_IDX: rd_next[7:0] = acc_cfg_reg & ~(8'h01 << ACCUM_BIT);
      RLO_IDX: rd_next[7:0] = fmtd[7:0];
      RHI_IDX: rd_next[7:0] = fmtd[15:8];
      CTL_IDX: rd_next[1:0] = ctl_reg;
      STS_IDX: rd_next[7:0] = sts_reg;
      MSK_IDX: rd_next[7:0] = msk_reg;
      default: hit = 1'b0;
    endcase
  end

  // apb answer: pready high in the first access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup & ~pwrite) ? rd_next : '0;
    end
  end

  // software-written configuration
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg     <= CFG_RST;
      acc_cfg_reg <= ACC_RST;
      ctl_reg     <= CTL_RST[1:0];
      msk_reg     <= '0;
    end else if (wr) begin
      if (idx == CFG_IDX)
        cfg_reg <= pwdata[7:0];
      if (idx == ACC_IDX)
        acc_cfg_reg <= pwdata[7:0];
      if (idx == CTL_IDX)
        ctl_reg <= pwdata[1:0];
      if (idx == MSK_IDX)
        msk_reg <= pwdata[7:0];
    end
  end

  // ==========================================================
  // conversion clock divider
  logic [4:0] div_cnt;
  logic       src_tick, sar_tick;

  // system clock source, oscillator edges in burst mode
  assign src_tick = burst ? (lp_s2 & ~lp_s3) : 1'b1;
  // one conversion clock per divider plus one source ticks
  assign sar_tick = src_tick && div_cnt >= div;

  always_ff @(posedge clk) begin
    if (reset)
      div_cnt <= '0;
    else if (src_tick)
      div_cnt <= sar_tick ? 5'h00 : div_cnt + 5'h01;
  end

  // ==========================================================
  // conversion sequencer
  acfg_state_t state_reg;
  logic [1:0]  track_cnt;
  logic [6:0]  burst_cnt;
  logic        done_rise, last_conv, done_evt, first_conv;

  assign done_rise  = res_s2.done & ~done_s3;
  assign last_conv  = !burst || burst_cnt >= acfg_rpt_last(rpt);
  assign done_evt   = state_reg == SQ_WAIT && done_rise && last_conv;
  assign first_conv = burst_cnt == 7'h00;

  // delayed track before each conversion, burst length
  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      state_reg <= SQ_IDLE;
      track_cnt <= '0;
      burst_cnt <= '0;
    end else begin
      case (state_reg)
        SQ_IDLE: begin
          track_cnt <= '0;
          burst_cnt <= '0;
          if (start_go)
            state_reg <= delayed ? SQ_TRACK : SQ_CONV;
        end
        SQ_TRACK: begin
          if (sar_tick) begin
            track_cnt <= track_cnt + 2'h1;
            if (track_cnt == TRACK_CYCLES - 2'h1)
              state_reg <= SQ_CONV;
          end
        end
        SQ_CONV: begin
          track_cnt <= '0;
          state_reg <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (done_rise) begin
            if (last_conv) begin
              state_reg <= SQ_IDLE;
            end else begin
              burst_cnt <= burst_cnt + 7'h01;
              state_reg <= delayed ? SQ_TRACK : SQ_CONV;
            end
          end
        end
        default: state_reg <= SQ_IDLE;
      endcase
    end
  end

  // ==========================================================
  // result accumulator
  wire [15:0] new_res = {4'h0, res_s2.data};

  // converter results win over a software byte write in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      accum_reg <= '0;
    end else if (state_reg == SQ_WAIT && done_rise) begin
      // overwrite or add; a burst starts fresh then adds
      if (burst ? !first_conv : accsel)
        accum_reg <= accum_reg + new_res;
      else
        accum_reg <= new_res;
    end else if (wr && idx == RLO_IDX) begin
      accum_reg[7:0] <= pwdata[7:0];
    end else if (wr && idx == RHI_IDX) begin
      accum_reg[15:8] <= pwdata[7:0];
    end
  end

  // ==========================================================
  // status, mask and interrupt
  // done flag, set wins over a write-one clear
  always_comb begin
    sts_next = sts_reg;
    if (wr && idx == STS_IDX)
      sts_next = sts_reg & ~pwdata[7:0];
    if (done_evt)
      sts_next[DONE_BIT] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sts_reg <= '0;
      irq     <= 1'b0;
    end else begin
      sts_reg <= sts_next;
      irq     <= |(sts_reg & msk_reg);
    end
  end

  // ==========================================================
  // converter controls
  always_ff @(posedge clk) begin
    if (reset) begin
      conv_ctl <= '0;
    end else begin
      conv_ctl.sar_clk    <= div_cnt <= (div >> 1);
      conv_ctl.conv_start <= state_reg == SQ_CONV;
      conv_ctl.gain       <= cfg_reg[GAIN_BIT];
      if (twelve)
        conv_ctl.res_mode <= RES12;
      else if (cfg_reg[EIGHT_BIT])
        conv_ctl.res_mode <= RES8;
      else
        conv_ctl.res_mode <= RES10;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_start_delayed;
    state_reg == SQ_IDLE && enable && start_go && delayed;
  endsequence

  sequence s_single_done;
    state_reg == SQ_WAIT && done_rise && !burst && enable;
  endsequence

  chk_sysclk_div_one: assert property (
    !burst && div == 5'h01 && $stable(div) && sar_tick
    |=> !sar_tick || burst || div == 5'h00)
    else $error("divider by two ticked on consecutive cycles");

  chk_burst_src_hold: assert property (
    burst && !(lp_s2 & ~lp_s3) |=> $stable(div_cnt))
    else $error("divider moved without an oscillator edge");

  chk_twelve_wins: assert property (
    twelve |=> conv_ctl.res_mode == RES12)
    else $error("12-bit select did not take precedence");

  chk_delay_track: assert property (
    s_start_delayed |=> (state_reg == SQ_TRACK && !conv_ctl.conv_start) [*2])
    else $error("delayed track did not hold off conversion");

  chk_gain_follow: assert property (
    $rose(cfg_reg[GAIN_BIT]) |=> conv_ctl.gain)
    else $error("gain select not driven");

  chk_result_replace: assert property (
    (s_single_done and !accsel) |=> accum_reg == $past(new_res))
    else $error("result not overwritten");

  chk_result_accum: assert property (
    (s_single_done and accsel) |=> accum_reg == 16'($past(accum_reg) + $past(new_res)))
    else $error("result not accumulated");

  chk_accum_bit_zero: assert property (
    setup && !pwrite && idx == ACC_IDX |=> prdata[ACCUM_BIT] == 1'b0)
    else $error("accumulate bit read back nonzero");

  chk_done_flag_set: assert property (
    done_evt |=> sts_reg[DONE_BIT] ##1 1'b1)
    else $error("done flag not set at end of conversion");

endmodule

// >>> acfg_conv_model.sv
// converter stand-in answering each start pulse with one result
`timescale 1ns/100ps
module acfg_conv_model
  import acfg_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        reset,
  // converter side
  input  wire acfg_ctl_t   ctl,
  input  wire logic [11:0] sample,
  output acfg_res_t        res
);
  logic [3:0] cnt;

  // ==========================================
  // result timing
  // one result per start
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 4'h0;
      res <= '0;
    end else if (ctl.conv_start) begin
      cnt <= 4'hc;
      res <= {1'b0, sample};
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h7) res.done <= 1'b1; // data settled before this
      if (cnt == 4'h1) res <= {1'b0, ~res.data}; // released, data no longer held
    end
  end
endmodule

// >>> tb_adc_clock_mode_accumulator_config.sv
// self-checking bench for the converter configuration block
`timescale 1ns/100ps
module tb_adc_clock_mode_accumulator_config
  import acfg_pkg::*;
;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, lposc_clk, irq, err, ls;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] smp;
  acfg_res_t   res;
  acfg_ctl_t   ctl;
  int          fails, checks_done, cyc, n, st, np;

  // ==========================================
  // clocks and timeout
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    lposc_clk = 1'b0;
    forever #25 lposc_clk = ~lposc_clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      summarize();
    end
  end

  acfg_top i_acfg_top (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lposc_clk(lposc_clk), .conv_res(res), .conv_ctl(ctl), .irq(irq));
  acfg_conv_model i_acfg_conv_model (.clk(clk), .reset(reset), .ctl(ctl), .sample(smp),
    .res(res));

  // ==========================================
  // bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cw(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
    repeat (2) @(posedge clk); // let registered outputs follow
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), {24'h0, exp}, rd);
  endtask
  // start, note when the start pulse shows, wait for the interrupt, clear it
  task automatic conv(input logic [7:0] cmd, input logic [11:0] s);
    smp <= s;
    xfer(1'b1, CTL_IDX, cmd);
    n = 0;
    st = 0;
    np = 0;
    while (irq !== 1'b1) begin
      @(posedge clk);
      n++;
      if (ctl.conv_start === 1'b1 && st == 0) st = n;
      if (ctl.conv_start === 1'b1) np++;
    end
    cw(STS_IDX, 8'h01);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  // count conversion clock rises over a window of system clocks
  task automatic rises(input int len);
    n = 0;
    ls = ctl.sar_clk;
    repeat (len) begin
      @(posedge clk);
      if (ctl.sar_clk === 1'b1 && ls === 1'b0) n++;
      ls = ctl.sar_clk;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // test sequence
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, smp} = {1'b1, 57'h0};
    {fails, checks_done} = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rdc(CFG_IDX, CFG_RST);
    rdc(ACC_IDX, ACC_RST);
    rdc(RHI_IDX, 8'h00);
    xfer(1'b0, 8'h55, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, err});
    cw(ACC_IDX, 8'hc0);
    rdc(ACC_IDX, 8'h80);
    cw(CFG_IDX, 8'h1c);
    chk("res mode", {30'h0, RES12}, {30'h0, ctl.res_mode});
    cw(ACC_IDX, 8'h00);
    chk("res mode", {30'h0, RES8}, {30'h0, ctl.res_mode});
    $display("test registers done");
    // count conversion clock rises over 40 cycles for two divider values
    for (int d = 1; d < 4; d += 2) begin
      cw(CFG_IDX, {d[4:0], 3'b001});
      chk("gain", 32'h1, {31'h0, ctl.gain});
      chk("res mode", {30'h0, RES10}, {30'h0, ctl.res_mode});
      rises(40);
      chk("divider rises", 40 / (d + 1), n);
    end
    $display("test divider done");
    cw(CFG_IDX, 8'h09);
    cw(MSK_IDX, 8'h01);
    cw(CTL_IDX, 8'h01);
    conv(8'h05, 12'h1a5);
    chk("prompt start", 32'h1, {31'h0, st <= 4});
    rdc(RLO_IDX, 8'ha5);
    rdc(RHI_IDX, 8'h01);
    conv(8'h05, 12'h0f3);
    rdc(RHI_IDX, 8'h00);
    cw(ACC_IDX, 8'h40);
    conv(8'h05, 12'h0f3);
    rdc(RLO_IDX, 8'he6);
    rdc(RHI_IDX, 8'h01);
    cw(RLO_IDX, 8'h00);
    cw(RHI_IDX, 8'h00);
    rdc(RLO_IDX, 8'h00);
    conv(8'h05, 12'h1a5);
    for (int k = 0; k < 4; k++) begin
      cw(ACC_IDX, {2'b00, k[2:0], 3'b000});
      rdc(RLO_IDX, 8'(12'h1a5 >> k));
    end
    cw(ACC_IDX, 8'h20);
    rdc(RHI_IDX, 8'h69);
    cw(ACC_IDX, 8'h00);
    cw(RHI_IDX, 8'h12);
    rdc(RHI_IDX, 8'h12);
    cw(CFG_IDX, 8'h0b);
    conv(8'h05, 12'h000);
    chk("delayed start", 32'h1, {31'h0, st >= 7 && st <= 8});
    $display("test conversions done");
    cw(CFG_IDX, 8'h09);
    cw(CTL_IDX, 8'h03);
    cw(ACC_IDX, 8'h01); // repeat code set only while burst is on
    conv(8'h07, 12'h100);
    chk("burst starts", 32'h4, np);
    rdc(RHI_IDX, 8'h04);
    rdc(RLO_IDX, 8'h00);
    rises(400);
    chk("burst divider", 32'h1, {31'h0, n >= 31 && n <= 33});
    cw(CFG_IDX, 8'h0b);
    conv(8'h07, 12'h010);
    chk("burst delayed start", 32'h1, {31'h0, st > 24 && st < 44});
    rdc(RLO_IDX, 8'h40);
    $display("test burst done");
    summarize();
  end
endmodule
